// ==== rtl/ecr_pkg.sv ====
/*
  constants, types and command codes for the eeprom and crc command block.
  assumes one 125 MHz clock and an 8-bit register port beside it.
*/
// Notes on behaviour
// - write takes address low-first, then programs data
// - write runs until the host sends idle
// - programming cycle: up to 16 bytes, 5.8 ms
// - 16-byte buffer; program on block end or empty
// - done flag high when drained, raises tx event
// - idle ignored while write still programming
// - write stays active; new data continues addresses
// - block zero writes flag violation, never program
// - eeprom addresses wrap modulo 200h
// - read waits for three args, copies into fifo
// - read ends itself after the last byte
// - reading key blocks flags access violation
// - config load copies 32 bytes to 10h-2Fh
// - config load from key blocks flags violation
// - startup runs config load from address 10h
// - crc command feeds every fifo byte to crc
// - crc waits on empty fifo until idle
// - short crc uses x^8+x^4+x^3+x^2+1
// - long crc uses x^16+x^12+x^5+1
// - crc done rise raises tx event, result valid
// - access violation also raises the summary flag
package ecr_pkg;

  // command codes
  localparam logic [7:0] CMD_IDLE   = 8'h00;
  localparam logic [7:0] CMD_WRITE  = 8'h01;
  localparam logic [7:0] CMD_READ   = 8'h03;
  localparam logic [7:0] CMD_CONFIG = 8'h07;
  localparam logic [7:0] CMD_CRC    = 8'h12;

  // register offsets
  localparam logic [5:0] REG_CMD      = 6'h01;
  localparam logic [5:0] REG_STATUS   = 6'h02;
  localparam logic [5:0] REG_ERROR    = 6'h03;
  localparam logic [5:0] REG_REDUND   = 6'h04;
  localparam logic [5:0] REG_SEED_LO  = 6'h05;
  localparam logic [5:0] REG_SEED_HI  = 6'h06;
  localparam logic [5:0] REG_OUT_LO   = 6'h07;
  localparam logic [5:0] REG_OUT_HI   = 6'h08;

  // field positions
  localparam int ST_EE_DONE_BIT  = 0;
  localparam int ST_CRC_DONE_BIT = 1;
  localparam int ST_TX_EVT_BIT   = 2;
  localparam int ST_ERR_SUM_BIT  = 3;
  localparam int ER_VIOL_BIT     = 0;
  localparam int ER_CRC_BAD_BIT  = 1;
  localparam int RC_SHORT_BIT    = 0;
  localparam int RC_HDLC_BIT     = 1;

  // reset values
  localparam logic [1:0] REDUND_RESET = 2'h0;
  localparam logic [7:0] SEED_LO_RST  = 8'hff;
  localparam logic [7:0] SEED_HI_RST  = 8'hff;

  // eeprom geometry
  localparam int         EE_AW        = 9;
  localparam int         BLK_BYTES    = 16;
  localparam logic [8:0] STARTUP_ADDR = 9'h010;
  localparam logic [7:0] CFG_BYTES    = 8'h20;
  localparam logic [5:0] CFG_FIRST    = 6'h10;

  // crc polynomials in bit-reversed form and check residues
  localparam logic [7:0]  POLY8_REV   = 8'hb8;
  localparam logic [15:0] POLY16_REV  = 16'h8408;
  localparam logic [15:0] RESID_PLAIN = 16'h0000;
  localparam logic [15:0] RESID_HDLC  = 16'hf0b8;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS  = 5800000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ecr_bus_req_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ARG, ST_WR_DATA, ST_WR_PROG, ST_WR_WAIT,
    ST_CP_REQ, ST_CP_WAIT, ST_CP_PUT, ST_CRC
  } ecr_state_t;

endpackage

// ==== rtl/ecr_crc_unit.sv ====
/*
  one-byte crc step, lsb first, 8 or 16 bits wide.
  assumes the caller registers the result each accepted byte.
*/
`timescale 1ns/1ns
module ecr_crc_unit
  import ecr_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data,
  input  wire logic        short_sel,
  output logic      [15:0] crc_out
);

  logic [15:0] stage [0:8];

  assign stage[0] = crc_in;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      wire fb = stage[i][0] ^ data[i];
      // short form keeps the upper byte at zero
      assign stage[i+1] = short_sel ?
        {8'h00, (stage[i][7:0] >> 1) ^ (fb ? POLY8_REV : 8'h00)} :
        ((stage[i] >> 1) ^ (fb ? POLY16_REV : 16'h0000));
    end
  endgenerate

  assign crc_out = stage[8];

endmodule

// ==== rtl/ecr_cmd_core.sv ====
/*
  eeprom write, eeprom read, config load and crc command engine.
  assumes a first-word-fall-through fifo outside, an eeprom with one cycle
  read latency, and a register file outside for the config copy.
*/
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module ecr_cmd_core
  import ecr_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES
)(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire ecr_bus_req_t bus_req,
  output logic        [7:0] rd_data,
  input  wire logic         fifo_empty,
  input  wire logic         fifo_full,
  input  wire logic   [7:0] fifo_head,
  output logic              fifo_pop,
  output logic              fifo_push,
  output logic        [7:0] fifo_push_data,
  input  wire logic   [7:0] ee_rd_data,
  output logic              ee_rd,
  output logic              ee_wr,
  output logic        [8:0] ee_addr,
  output logic        [7:0] ee_wr_data,
  output logic              cfg_wr,
  output logic        [5:0] cfg_addr,
  output logic        [7:0] cfg_data
);

  ecr_state_t  st_q;
  logic [7:0]  cmd_q;
  logic [1:0]  arg_idx_q;
  logic [8:0]  ptr_q;
  logic [7:0]  cnt_q;
  logic [5:0]  cfg_ptr_q;
  logic [7:0]  buf_q [0:BLK_BYTES-1];
  logic [BLK_BYTES-1:0] valid_q;
  logic [4:0]  page_q;
  logic [3:0]  prog_idx_q;
  logic [19:0] wait_q;
  logic [15:0] crc_q;
  logic [15:0] crc_next;
  logic [1:0]  redund_q;
  logic [7:0]  seed_lo_q;
  logic [7:0]  seed_hi_q;
  logic        ee_done_q;
  logic        crc_done_q;
  logic        tx_evt_q;
  logic        viol_q;
  logic        err_sum_q;
  logic        crc_bad_q;
  logic        pop_q;
  logic        push_q;
  logic [7:0]  push_data_q;
  logic        ee_rd_q;
  logic        ee_wr_q;
  logic [8:0]  ee_addr_q;
  logic [7:0]  ee_wdata_q;
  logic        cfg_wr_q;
  logic [5:0]  cfg_addr_q;
  logic [7:0]  cfg_data_q;
  logic [7:0]  rd_data_q;

  // decode
  wire cmd_wr     = bus_req.wr && (bus_req.addr == REG_CMD);
  wire is_wr_st   = (st_q == ST_WR_DATA) || (st_q == ST_WR_PROG) ||
                    (st_q == ST_WR_WAIT) || (st_q == ST_ARG && cmd_q == CMD_WRITE);
  // write may only be left once everything is programmed
  wire idle_ok    = !is_wr_st || ee_done_q;
  wire do_idle    = cmd_wr && (bus_req.wdata == CMD_IDLE) && idle_ok;
  wire known_cmd  = (bus_req.wdata == CMD_WRITE) || (bus_req.wdata == CMD_READ) ||
                    (bus_req.wdata == CMD_CONFIG) || (bus_req.wdata == CMD_CRC);
  wire do_launch  = cmd_wr && known_cmd && (st_q == ST_IDLE);
  wire want_pop   = (st_q == ST_ARG) || (st_q == ST_CRC) ||
                    (st_q == ST_WR_DATA && valid_q[ptr_q[3:0]] == 1'b0);
  // one byte every other cycle so the fifo flag has caught up
  wire take       = want_pop && !fifo_empty && !pop_q && !cmd_wr;
  wire [1:0] last_arg = (cmd_q == CMD_READ) ? 2'd2 : 2'd1;
  wire blk0       = (ptr_q[8:4] == 5'h00);
  wire key_area   = (ptr_q[8:7] != 2'b00);
  wire drained    = fifo_empty && !pop_q;
  wire buf_any    = |valid_q;
  wire ee_done_d  = (st_q == ST_WR_DATA) && drained && !buf_any;
  wire crc_done_d = (st_q == ST_CRC) && drained;
  wire tx_rise    = (ee_done_d && !ee_done_q) || (crc_done_d && !crc_done_q);
  wire viol_set   = (st_q == ST_WR_DATA && take && blk0) ||
                    (st_q == ST_CP_REQ && key_area && cnt_q != 8'h00 &&
                     (cmd_q == CMD_CONFIG || !fifo_full));
  wire [15:0] crc_view = (redund_q[RC_HDLC_BIT] ? ~crc_q : crc_q) &
                         (redund_q[RC_SHORT_BIT] ? 16'h00ff : 16'hffff);
  wire [15:0] resid    = redund_q[RC_HDLC_BIT] ? RESID_HDLC : RESID_PLAIN;
  wire [7:0]  status_v = {4'h0, err_sum_q, tx_evt_q, crc_done_q, ee_done_q};
  wire [7:0]  error_v  = {6'h00, crc_bad_q, viol_q};

  logic [7:0] rd_mux;
  assign rd_mux = (bus_req.addr == REG_STATUS)  ? status_v :
                  (bus_req.addr == REG_ERROR)   ? error_v :
                  (bus_req.addr == REG_REDUND)  ? {6'h00, redund_q} :
                  (bus_req.addr == REG_SEED_LO) ? seed_lo_q :
                  (bus_req.addr == REG_SEED_HI) ? seed_hi_q :
                  (bus_req.addr == REG_OUT_LO)  ? crc_view[7:0] :
                  (bus_req.addr == REG_OUT_HI)  ? crc_view[15:8] :
                  (bus_req.addr == REG_CMD)     ? cmd_q : 8'h00;

  ecr_crc_unit u_crc (
    .crc_in    (crc_q),
    .data      (fifo_head),
    .short_sel (redund_q[RC_SHORT_BIT]),
    .crc_out   (crc_next)
  );

  // software-visible registers and flags; hardware set beats software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      redund_q  <= REDUND_RESET;
      seed_lo_q <= SEED_LO_RST;
      seed_hi_q <= SEED_HI_RST;
      tx_evt_q  <= 1'b0;
      viol_q    <= 1'b0;
      err_sum_q <= 1'b0;
      rd_data_q <= 8'h00;
      ee_done_q <= 1'b0;
      crc_done_q <= 1'b0;
      crc_bad_q <= 1'b0;
    end else if (ce) begin
      if (bus_req.wr && bus_req.addr == REG_REDUND) begin
        redund_q <= bus_req.wdata[1:0];
      end
      if (bus_req.wr && bus_req.addr == REG_SEED_LO) begin
        seed_lo_q <= bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == REG_SEED_HI) begin
        seed_hi_q <= bus_req.wdata;
      end
      tx_evt_q  <= tx_rise || (tx_evt_q && !(bus_req.wr && bus_req.addr == REG_STATUS &&
                   bus_req.wdata[ST_TX_EVT_BIT]));
      viol_q    <= viol_set || (viol_q && !(bus_req.wr && bus_req.addr == REG_ERROR &&
                   bus_req.wdata[ER_VIOL_BIT]));
      err_sum_q <= viol_q;
      ee_done_q <= ee_done_d;
      crc_done_q <= crc_done_d;
      crc_bad_q <= (crc_q != resid);
      rd_data_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // command sequencer; reset starts the power-up config copy
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q       <= ST_CP_REQ;
      cmd_q      <= CMD_CONFIG;
      ptr_q      <= STARTUP_ADDR;
      cnt_q      <= CFG_BYTES;
      cfg_ptr_q  <= CFG_FIRST;
      arg_idx_q  <= 2'd0;
      valid_q    <= '0;
      page_q     <= 5'h00;
      prog_idx_q <= 4'h0;
      wait_q     <= 20'h00000;
      crc_q      <= 16'h0000;
      pop_q      <= 1'b0;
      push_q     <= 1'b0;
      push_data_q <= 8'h00;
      ee_rd_q    <= 1'b0;
      ee_wr_q    <= 1'b0;
      ee_addr_q  <= 9'h000;
      ee_wdata_q <= 8'h00;
      cfg_wr_q   <= 1'b0;
      cfg_addr_q <= 6'h00;
      cfg_data_q <= 8'h00;
    end else if (ce) begin
      pop_q    <= take;
      push_q   <= 1'b0;
      ee_rd_q  <= 1'b0;
      ee_wr_q  <= 1'b0;
      cfg_wr_q <= 1'b0;
      if (do_idle) begin
        st_q  <= ST_IDLE;
        cmd_q <= CMD_IDLE;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (do_launch) begin
              cmd_q     <= bus_req.wdata;
              arg_idx_q <= 2'd0;
              valid_q   <= '0;
              crc_q     <= {seed_hi_q, seed_lo_q};
              cnt_q     <= CFG_BYTES;
              cfg_ptr_q <= CFG_FIRST;
              st_q      <= (bus_req.wdata == CMD_CRC) ? ST_CRC : ST_ARG;
            end
          end
          ST_ARG: begin
            if (take) begin
              // high byte keeps one bit only: addresses wrap at 200h
              case (arg_idx_q)
                2'd0:    ptr_q[7:0] <= fifo_head;
                2'd1:    ptr_q[8]   <= fifo_head[0];
                default: cnt_q      <= fifo_head;
              endcase
              arg_idx_q <= arg_idx_q + 2'd1;
              if (arg_idx_q == last_arg) begin
                st_q <= (cmd_q == CMD_WRITE) ? ST_WR_DATA : ST_CP_REQ;
              end
            end
          end
          ST_WR_DATA: begin
            if (take) begin
              if (!blk0) begin
                buf_q[ptr_q[3:0]]   <= fifo_head;
                valid_q[ptr_q[3:0]] <= 1'b1;
                page_q              <= ptr_q[8:4];
              end
              ptr_q <= ptr_q + 9'h001;
              if (ptr_q[3:0] == 4'hf && !blk0) begin
                st_q       <= ST_WR_PROG;
                prog_idx_q <= 4'h0;
              end
            end else if (drained && buf_any) begin
              st_q       <= ST_WR_PROG;
              prog_idx_q <= 4'h0;
            end
          end
          ST_WR_PROG: begin
            // one pass over the block, only loaded bytes are written
            if (valid_q[prog_idx_q]) begin
              ee_wr_q    <= 1'b1;
              ee_addr_q  <= {page_q, prog_idx_q};
              ee_wdata_q <= buf_q[prog_idx_q];
            end
            prog_idx_q <= prog_idx_q + 4'h1;
            if (prog_idx_q == 4'hf) begin
              valid_q <= '0;
              wait_q  <= 20'h00000;
              st_q    <= ST_WR_WAIT;
            end
          end
          ST_WR_WAIT: begin
            wait_q <= wait_q + 20'h00001;
            if (wait_q == 20'(PROG_CNT - 1)) begin
              st_q <= ST_WR_DATA;
            end
          end
          ST_CP_REQ: begin
            if (cnt_q == 8'h00) begin
              st_q  <= ST_IDLE;
              cmd_q <= CMD_IDLE;
            end else if (cmd_q == CMD_CONFIG || !fifo_full) begin
              if (key_area) begin
                st_q  <= ST_IDLE;
                cmd_q <= CMD_IDLE;
              end else begin
                ee_rd_q   <= 1'b1;
                ee_addr_q <= ptr_q;
                ptr_q     <= ptr_q + 9'h001;
                st_q      <= ST_CP_WAIT;
              end
            end
          end
          ST_CP_WAIT: begin
            st_q <= ST_CP_PUT;
          end
          ST_CP_PUT: begin
            if (cmd_q == CMD_READ) begin
              push_q      <= 1'b1;
              push_data_q <= ee_rd_data;
            end else begin
              cfg_wr_q   <= 1'b1;
              cfg_addr_q <= cfg_ptr_q;
              cfg_data_q <= ee_rd_data;
              cfg_ptr_q  <= cfg_ptr_q + 6'h01;
            end
            cnt_q <= cnt_q - 8'h01;
            st_q  <= ST_CP_REQ;
          end
          ST_CRC: begin
            if (take) begin
              crc_q <= crc_next;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign rd_data        = rd_data_q;
  assign fifo_pop       = pop_q;
  assign fifo_push      = push_q;
  assign fifo_push_data = push_data_q;
  assign ee_rd          = ee_rd_q;
  assign ee_wr          = ee_wr_q;
  assign ee_addr        = ee_addr_q;
  assign ee_wr_data     = ee_wdata_q;
  assign cfg_wr         = cfg_wr_q;
  assign cfg_addr       = cfg_addr_q;
  assign cfg_data       = cfg_data_q;

  chk_blk0_no_prog: assert property (@(posedge clk) disable iff (reset)
    ee_wr_q |-> ee_addr_q[8:4] != 5'h00) else $error("block zero programmed");
  chk_blk0_flags: assert property (@(posedge clk) disable iff (reset)
    (ce && st_q == ST_WR_DATA && take && blk0) |=> viol_q)
    else $error("block zero write not flagged");
  chk_done_event: assert property (@(posedge clk) disable iff (reset)
    $rose(ee_done_q) |-> tx_evt_q) else $error("done rise without tx event");
  chk_idle_refused: assert property (@(posedge clk) disable iff (reset)
    (ce && cmd_wr && bus_req.wdata == CMD_IDLE && is_wr_st && !ee_done_q) |=>
    st_q != ST_IDLE) else $error("write stopped while programming");
  chk_key_read: assert property (@(posedge clk) disable iff (reset)
    ee_rd_q |-> ee_addr_q[8:7] == 2'b00) else $error("key area read");
  chk_cfg_range: assert property (@(posedge clk) disable iff (reset)
    cfg_wr_q |-> (cfg_addr_q >= 6'h10 && cfg_addr_q <= 6'h2f))
    else $error("config write out of range");
  chk_crc_event: assert property (@(posedge clk) disable iff (reset)
    $rose(crc_done_q) |-> tx_evt_q) else $error("crc done without tx event");
  chk_err_summary: assert property (@(posedge clk) disable iff (reset)
    (ce && viol_q) |=> err_sum_q) else $error("summary flag missed");
  chk_read_latency: assert property (@(posedge clk) disable iff (reset)
    (ce && ee_rd_q && cmd_q == CMD_READ) ##1 ce |=> push_q)
    else $error("read byte not pushed");
  chk_prog_quiet: assert property (@(posedge clk) disable iff (reset)
    (ce && st_q == ST_WR_PROG) |=> !ee_done_q)
    else $error("done flag high while programming");
  chk_crc_no_data: assert property (@(posedge clk) disable iff (reset)
    (st_q == ST_CRC) |-> (!push_q && !ee_wr_q))
    else $error("crc command moved data");
  chk_host_launch: assert property (@(posedge clk) disable iff (reset)
    (ce && st_q == ST_IDLE && !cmd_wr) |=> st_q == ST_IDLE)
    else $error("command started without host");
  chk_copy_ends: assert property (@(posedge clk) disable iff (reset)
    (ce && st_q == ST_CP_REQ && cnt_q == 8'h00) |=> st_q == ST_IDLE)
    else $error("copy did not end itself");
  chk_prog_wait: assert property (@(posedge clk) disable iff (reset)
    (ce && st_q == ST_WR_WAIT && wait_q != 20'(PROG_CNT - 1)) |=> st_q == ST_WR_WAIT)
    else $error("programming cycle cut short");

endmodule

// ==== tb/ecr_far_model.sv ====
/*
  far-side model: fifo, eeprom array and config register sink.
  assumes the core's fifo and eeprom timing as given in its port notes.
*/
`timescale 1ns/1ns
module ecr_far_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       host_push,
  input  wire logic [7:0] host_data,
  input  wire logic       fifo_pop,
  input  wire logic       fifo_push,
  input  wire logic [7:0] fifo_push_data,
  input  wire logic       ee_rd,
  input  wire logic       ee_wr,
  input  wire logic [8:0] ee_addr,
  input  wire logic [7:0] ee_wr_data,
  input  wire logic       cfg_wr,
  input  wire logic [5:0] cfg_addr,
  input  wire logic [7:0] cfg_data,
  output logic            fifo_empty,
  output logic            fifo_full,
  output logic      [7:0] fifo_head,
  output logic      [7:0] ee_rd_data
);
  logic [7:0] mem [0:511];
  logic [7:0] fm [0:63];
  logic [7:0] cfg [0:63];
  logic [7:0] last_q;
  logic [7:0] ee_q;
  logic       ee_v_q;
  int         rp;
  int         wp;
  int         cnt;
  int         cfg_n;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'(i * 7 + i / 256);
    rp = 0;
    wp = 0;
    cnt = 0;
    cfg_n = 0;
    last_q = 8'h00;
    ee_q = 8'h00;
    ee_v_q = 1'b0;
  end
  // stale head and stale eeprom data show the inverse, so no old byte passes
  assign fifo_empty = (cnt == 0);
  assign fifo_full  = (cnt == 64);
  assign fifo_head  = fifo_empty ? ~last_q : fm[rp];
  assign ee_rd_data = ee_v_q ? ee_q : ~ee_q;
  always @(posedge clk) begin
    ee_v_q <= ee_rd;
    if (ee_rd) ee_q <= mem[ee_addr];
    if (ee_wr) mem[ee_addr] <= ee_wr_data;
    if (cfg_wr) cfg[cfg_addr] <= cfg_data;
    if (cfg_wr) cfg_n <= cfg_n + 1;
    if (reset) begin
      rp <= 0;
      wp <= 0;
      cnt <= 0;
    end else begin
      if (fifo_pop && cnt > 0) last_q <= fm[rp];
      if (fifo_pop && cnt > 0) rp <= (rp + 1) % 64;
      if (host_push || fifo_push) fm[wp] <= host_push ? host_data : fifo_push_data;
      if (host_push || fifo_push) wp <= (wp + 1) % 64;
      cnt <= cnt + ((host_push || fifo_push) ? 1 : 0) - ((fifo_pop && cnt > 0) ? 1 : 0);
    end
  end
endmodule

// ==== tb/tb_eeprom_and_crc_commands.sv ====
/*
  self-checking bench for the eeprom and crc command core.
  assumes the far-side model and a 20-cycle programming time.
*/
`timescale 1ns/1ns
module tb_eeprom_and_crc_commands import ecr_pkg::*;;
  typedef struct packed {
    logic [1:0]  ctrl;
    logic [15:0] seed;
    logic [7:0]  d0;
    logic [7:0]  d1;
  } ecr_row_t;
  logic         clk;
  logic         reset;
  logic         ce;
  logic         host_push;
  logic [7:0]   host_data;
  ecr_bus_req_t bus_req;
  logic [7:0]   rd_data;
  logic         fifo_empty;
  logic         fifo_full;
  logic [7:0]   fifo_head;
  logic         fifo_pop;
  logic         fifo_push;
  logic [7:0]   fifo_push_data;
  logic [7:0]   ee_rd_data;
  logic         ee_rd;
  logic         ee_wr;
  logic [8:0]   ee_addr;
  logic [7:0]   ee_wr_data;
  logic         cfg_wr;
  logic [5:0]   cfg_addr;
  logic [7:0]   cfg_data;
  int           miscompares;
  int           tests_run;
  logic [7:0]   v;
  logic [16:0]  e;
  logic [7:0]   q [$];
  ecr_row_t     rows [4] = '{'{2'b00, 16'h6363, 8'h12, 8'h34},
    '{2'b01, 16'h00a5, 8'h12, 8'h34}, '{2'b10, 16'hffff, 8'h12, 8'h34},
    '{2'b01, 16'h0000, 8'h00, 8'h00}};

  ecr_cmd_core #(.PROG_CNT(20)) dut_u (.clk(clk), .reset(reset), .ce(ce),
    .bus_req(bus_req), .rd_data(rd_data), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
    .fifo_head(fifo_head), .fifo_pop(fifo_pop), .fifo_push(fifo_push),
    .fifo_push_data(fifo_push_data), .ee_rd_data(ee_rd_data), .ee_rd(ee_rd), .ee_wr(ee_wr),
    .ee_addr(ee_addr), .ee_wr_data(ee_wr_data), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data));
  ecr_far_model model_u (.clk(clk), .reset(reset), .host_push(host_push),
    .host_data(host_data), .fifo_pop(fifo_pop), .fifo_push(fifo_push),
    .fifo_push_data(fifo_push_data), .ee_rd(ee_rd), .ee_wr(ee_wr), .ee_addr(ee_addr),
    .ee_wr_data(ee_wr_data), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full), .fifo_head(fifo_head),
    .ee_rd_data(ee_rd_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [16:0] crc_exp(input ecr_row_t w);
    logic [15:0] r;
    r = w.ctrl[0] ? {8'h00, w.seed[7:0]} : w.seed;
    for (int k = 0; k < 2; k++) begin
      r = r ^ {8'h00, (k == 0) ? w.d0 : w.d1};
      for (int j = 0; j < 8; j++)
        if (w.ctrl[0]) r = {8'h00, r[0] ? (r[7:0] >> 1) ^ POLY8_REV : r[7:0] >> 1};
        else r = r[0] ? (r >> 1) ^ POLY16_REV : r >> 1;
    end
    return {r !== (w.ctrl[1] ? RESID_HDLC : RESID_PLAIN), w.ctrl[1] ? ~r : r};
  endfunction

  task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
    tests_run++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] m,
                      input logic [7:0] x);
    logic [7:0] d;
    rd_reg(a, d);
    check(n, {8'h00, d & m}, {8'h00, x});
  endtask
  // bounded wait on a register field; slow programming just takes more reads
  task automatic poll(input logic [5:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] d;
    d = ~x;
    for (int i = 0; i < 400 && (d & m) !== x; i++) rd_reg(a, d);
    check("poll", {8'h00, d & m}, {8'h00, x});
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk) host_push <= 1'b1;
    host_data <= b;
    @(posedge clk) host_push <= 1'b0;
  endtask
  task automatic run(input logic [7:0] c);
    foreach (q[i]) push(q[i]);
    wr_reg(REG_CMD, c);
  endtask
  task automatic check_cfg(input int base);
    check("cfg count", 16'(model_u.cfg_n), 16'd32);
    for (int i = 0; i < 32; i++)
      check("cfg byte", {8'h00, model_u.cfg[16 + i]},
            {8'h00, model_u.mem[base + i]});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // whole run needs some 800 cycles; 50000 leaves room for slow polls
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    host_push = 1'b0;
    host_data = 8'h00;
    bus_req = '0;
    miscompares = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 600 && model_u.cfg_n < 32; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    check_cfg(16);
    rchk("unmapped", 6'h3f, 8'hff, 8'h00);
    rchk("seed low", REG_SEED_LO, 8'hff, SEED_LO_RST);
    foreach (rows[r]) begin
      wr_reg(REG_REDUND, {6'h00, rows[r].ctrl});
      wr_reg(REG_SEED_LO, rows[r].seed[7:0]);
      wr_reg(REG_SEED_HI, rows[r].seed[15:8]);
      wr_reg(REG_STATUS, 8'h04);
      push(rows[r].d0);
      wr_reg(REG_CMD, CMD_CRC);
      repeat (6) @(posedge clk);
      push(rows[r].d1);
      repeat (10) @(posedge clk);
      poll(REG_STATUS, 8'h06, 8'h06);
      e = crc_exp(rows[r]);
      rchk("crc low", REG_OUT_LO, 8'hff, e[7:0]);
      rchk("crc high", REG_OUT_HI, 8'hff, e[15:8]);
      rchk("crc bad", REG_ERROR, 8'h02, {6'h00, e[16], 1'b0});
      rchk("crc busy", REG_CMD, 8'hff, CMD_CRC);
      wr_reg(REG_CMD, CMD_IDLE);
    end
    // a write while the enable is low must leave the seed untouched
    ce <= 1'b0;
    wr_reg(REG_SEED_LO, 8'h5a);
    ce <= 1'b1;
    rchk("frozen seed", REG_SEED_LO, 8'hff, rows[3].seed[7:0]);
    wr_reg(REG_STATUS, 8'h04);
    q = '{8'h6c, 8'h01, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
    run(CMD_WRITE);
    wr_reg(REG_CMD, CMD_IDLE);
    rchk("write held", REG_CMD, 8'hff, CMD_WRITE);
    rchk("done low", REG_STATUS, 8'h01, 8'h00);
    poll(REG_STATUS, 8'h05, 8'h05);
    for (int i = 0; i < 5; i++)
      check("prog byte", {8'h00, model_u.mem[9'h16c + i]},
            {8'h00, q[2 + i]});
    push(8'ha5);
    repeat (6) @(posedge clk);
    poll(REG_STATUS, 8'h01, 8'h01);
    check("next addr", {8'h00, model_u.mem[9'h171]}, 16'h00a5);
    wr_reg(REG_CMD, CMD_IDLE);
    rchk("write ended", REG_CMD, 8'hff, CMD_IDLE);
    v = model_u.mem[5];
    q = '{8'h05, 8'h00, 8'h3c};
    run(CMD_WRITE);
    repeat (10) @(posedge clk);
    poll(REG_STATUS, 8'h01, 8'h01);
    rchk("zero viol", REG_ERROR, 8'h01, 8'h01);
    rchk("err summary", REG_STATUS, 8'h08, 8'h08);
    check("zero kept", {8'h00, model_u.mem[5]}, {8'h00, v});
    wr_reg(REG_CMD, CMD_IDLE);
    wr_reg(REG_ERROR, 8'h01);
    q = '{8'h70, 8'h00};
    run(CMD_CONFIG);
    poll(REG_CMD, 8'hff, CMD_IDLE);
    rchk("cfg viol", REG_ERROR, 8'h01, 8'h01);
    wr_reg(REG_ERROR, 8'h01);
    model_u.cfg_n = 0;
    q = '{8'h40, 8'h00};
    run(CMD_CONFIG);
    poll(REG_CMD, 8'hff, CMD_IDLE);
    check_cfg(64);
    q = '{8'h80, 8'h00, 8'h01};
    run(CMD_READ);
    poll(REG_CMD, 8'hff, CMD_IDLE);
    rchk("key viol", REG_ERROR, 8'h01, 8'h01);
    wr_reg(REG_ERROR, 8'h01);
    q = '{8'h1f, 8'h02, 8'h02};
    run(CMD_READ);
    poll(REG_CMD, 8'hff, CMD_IDLE);
    for (int i = 0; i < 2; i++)
      check("read byte", {8'h00, model_u.fm[(model_u.rp + i) % 64]},
            {8'h00, model_u.mem[31 + i]});
    check("read count", 16'(model_u.cnt), 16'd2);
    // reset in mid-run must repeat the power-up copy and clear the flags
    @(posedge clk) reset <= 1'b1;
    model_u.cfg_n = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 600 && model_u.cfg_n < 32; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    check_cfg(16);
    rchk("reset status", REG_STATUS, 8'hff, 8'h00);
    stop_test();
  end
endmodule
